/* hw/phy_power_mode_control.sv */
// Power-mode sequencer with LED and general clock output control.
// Assumes straps, line detectors and MAC requests arrive as levels; pins are
// synchronised here, signals from core logic on clk are used directly.

module phy_power_mode_control #(
  parameter int MAC_WIDTH      = 4,
  parameter int WAKE_CYCLES    = phy_pm_pkg::WAKE_CYCLES_DEF,
  parameter int SILENCE_CYCLES = phy_pm_pkg::SILENCE_CYCLES_DEF,
  parameter int PULSE_CYCLES   = phy_pm_pkg::PULSE_CYCLES_DEF,
  parameter int REFRESH_CYCLES = phy_pm_pkg::REFRESH_CYCLES_DEF,
  parameter int BLINK_CYCLES   = phy_pm_pkg::BLINK_CYCLES_DEF
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 reset_pin_n,
  input  wire logic                 strap_soft_pd,
  input  wire logic                 strap_edpd_en,
  input  wire logic                 strap_eee_en,
  input  wire logic                 led_pin_in,
  output logic                      led_pin_out,
  output logic                      led_pin_oe,
  input  wire logic [15:0]          mgmt_addr,
  input  wire logic [15:0]          mgmt_wdata,
  input  wire logic                 mgmt_wr,
  input  wire logic                 mgmt_rd,
  output logic      [15:0]          mgmt_rdata,
  output logic                      mgmt_ack,
  input  wire logic                 line_energy,
  input  wire logic                 partner_wake,
  input  wire logic                 recovered_clock_in,
  input  wire logic                 link_up,
  input  wire logic                 link_speed_100,
  input  wire logic                 partner_adv_100,
  input  wire logic                 link_activity,
  input  wire logic                 frame_active,
  input  wire logic                 mac_lpi_req,
  input  wire logic [MAC_WIDTH-1:0] core_rxd,
  input  wire logic                 core_rx_ctl,
  input  wire logic                 core_rx_clk,
  output logic      [MAC_WIDTH-1:0] mac_rxd,
  output logic                      mac_rx_ctl,
  output logic                      receive_clock_out,
  output logic                      mac_out_oe,
  output logic                      general_clock_out,
  output logic                      clock_multiplier_en,
  output logic                      core_clock_en,
  output logic                      analog_en,
  output logic                      line_receive_en,
  output logic                      link_bringup_start,
  output logic                      link_pulse,
  output logic                      lpi_refresh,
  output logic                      phy_ready,
  output phy_pm_pkg::pm_mode_t      power_mode
);
  import phy_pm_pkg::*;

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (MAC_WIDTH < 1 || WAKE_CYCLES < 1 || SILENCE_CYCLES < 1 || PULSE_CYCLES < 1 ||
      REFRESH_CYCLES < 1 || BLINK_CYCLES < 1) begin : g_bad_param
    $error("phy_power_mode_control: counts and widths must be at least one");
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // saturating counter step
  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    return (v == 32'hffff_ffff) ? v : v + 32'h0000_0001;
  endfunction

  // true once a counter has run its full period
  function automatic logic reached(input logic [31:0] v, input int lim);
    return v >= 32'(lim - 1);
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                 rp1;
    logic                 rp2;
    logic                 rp3;
    logic [2:0]           st1;
    logic [2:0]           st2;
    logic                 ld1;
    logic                 ld2;
    logic                 en1;
    logic                 en2;
    logic                 wk1;
    logic                 wk2;
    logic                 rc1;
    logic                 rc2;
    pm_mode_t             mode;
    logic                 led_active_low;
    logic [15:0]          basic_ctl;
    logic [15:0]          cs2;
    logic [15:0]          led_ctl;
    logic [15:0]          lp_adv;
    logic [15:0]          gpc;
    logic [31:0]          silence_cnt;
    logic [31:0]          pulse_cnt;
    logic [31:0]          wake_cnt;
    logic [31:0]          blink_cnt;
    logic                 blink_ph;
    logic [2:0]           div_cnt;
    logic                 gpclk;
    logic [15:0]          rdata;
    logic                 ack;
    logic [MAC_WIDTH-1:0] rxd;
    logic                 rx_ctl;
    logic                 rxclk;
    logic                 pulse;
    logic                 refresh;
    logic                 bringup;
    logic                 led_out;
  } state_t;

  localparam state_t STATE_RST = '{
    mode:      MODE_HW_PD,
    basic_ctl: BASIC_CONTROL_RST,
    cs2:       CS2_RST,
    led_ctl:   LED_CONTROL_RST,
    lp_adv:    LOWPOWER_ADV_RST,
    gpc:       GP_CLOCK_RST,
    default:   '0
  };

  state_t s;
  state_t next_s;

  logic       soft_pd;
  logic       edpd_en;
  logic       eee_link;
  logic       gp_en;
  logic [1:0] gp_sel;
  logic       release_edge;
  logic       led_lit;

  // decoded controls
  assign soft_pd      = s.basic_ctl[BC_SOFT_PD_BIT];
  assign edpd_en      = s.cs2[CS2_EDPD_EN_BIT];
  assign eee_link     = s.lp_adv[ADV_100_BIT] && partner_adv_100 &&
                        link_speed_100 && link_up;
  assign gp_en        = s.gpc[GPC_ENABLE_BIT];
  assign gp_sel       = s.gpc[GPC_SEL_LSB +: 2];
  assign release_edge = s.rp2 && !s.rp3;

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    led_lit = 1'b0;

    // pin synchronisers
    next_s.rp1 = reset_pin_n;
    next_s.rp2 = s.rp1;
    next_s.rp3 = s.rp2;
    next_s.st1 = {strap_eee_en, strap_edpd_en, strap_soft_pd};
    next_s.st2 = s.st1;
    next_s.ld1 = led_pin_in;
    next_s.ld2 = s.ld1;
    next_s.en1 = line_energy;
    next_s.en2 = s.en1;
    next_s.wk1 = partner_wake;
    next_s.wk2 = s.wk1;
    next_s.rc1 = recovered_clock_in;
    next_s.rc2 = s.rc1;

    next_s.pulse   = 1'b0;
    next_s.refresh = 1'b0;
    next_s.bringup = 1'b0;
    next_s.ack     = 1'b0;

    // mode sequencing, hardware power-down first
    if (!s.rp2) begin
      next_s.mode        = MODE_HW_PD;
      next_s.basic_ctl   = BASIC_CONTROL_RST;
      next_s.cs2         = CS2_RST;
      next_s.led_ctl     = LED_CONTROL_RST;
      next_s.lp_adv      = LOWPOWER_ADV_RST;
      next_s.gpc         = GP_CLOCK_RST;
      next_s.silence_cnt = '0;
      next_s.pulse_cnt   = '0;
      next_s.wake_cnt    = '0;
    end else if (soft_pd || (release_edge && s.st2[0])) begin
      // a strapped soft power-down goes straight there, no link bring-up
      next_s.mode        = MODE_SOFT_PD;
      next_s.silence_cnt = '0;
      next_s.pulse_cnt   = '0;
      next_s.wake_cnt    = '0;
    end else begin
      unique case (s.mode)
        MODE_HW_PD, MODE_SOFT_PD: begin
          next_s.mode        = MODE_NORMAL;
          next_s.bringup     = 1'b1;
          next_s.silence_cnt = '0;
        end
        MODE_NORMAL: begin
          if (s.en2 || link_up) begin
            next_s.silence_cnt = '0;
          end else begin
            next_s.silence_cnt = sat_inc(s.silence_cnt);
          end
          if (edpd_en && !link_up && reached(s.silence_cnt, SILENCE_CYCLES)) begin
            next_s.mode      = MODE_ENERGY_PD;
            next_s.pulse_cnt = '0;
          end else if (eee_link && mac_lpi_req && !frame_active) begin
            next_s.mode      = MODE_LPI;
            next_s.pulse_cnt = '0;
          end
        end
        MODE_ENERGY_PD: begin
          if (s.en2) begin
            next_s.mode        = MODE_NORMAL;
            next_s.bringup     = 1'b1;
            next_s.silence_cnt = '0;
          end else if (reached(s.pulse_cnt, PULSE_CYCLES)) begin
            next_s.pulse_cnt = '0;
            next_s.pulse     = 1'b1;
          end else begin
            next_s.pulse_cnt = sat_inc(s.pulse_cnt);
          end
        end
        MODE_LPI: begin
          if (!mac_lpi_req || s.wk2 || !eee_link) begin
            next_s.mode     = MODE_WAKE;
            next_s.wake_cnt = '0;
          end else if (reached(s.pulse_cnt, REFRESH_CYCLES)) begin
            next_s.pulse_cnt = '0;
            next_s.refresh   = 1'b1;
          end else begin
            next_s.pulse_cnt = sat_inc(s.pulse_cnt);
          end
        end
        MODE_WAKE: begin
          if (reached(s.wake_cnt, WAKE_CYCLES)) begin
            next_s.mode        = MODE_NORMAL;
            next_s.silence_cnt = '0;
          end else begin
            next_s.wake_cnt = sat_inc(s.wake_cnt);
          end
        end
        default: next_s.mode = MODE_HW_PD;                           // illegal code
      endcase
    end

    // strap capture on reset pin release
    if (release_edge) begin
      next_s.basic_ctl[BC_SOFT_PD_BIT] = s.st2[0];
      next_s.cs2[CS2_EDPD_EN_BIT]      = s.st2[1];
      next_s.lp_adv[ADV_100_BIT]       = s.st2[2];
      next_s.led_active_low            = s.ld2;
    end

    // management access, refused while in hardware power-down
    if (s.rp2 && s.mode != MODE_HW_PD && !release_edge && (mgmt_wr || mgmt_rd)) begin
      next_s.ack = 1'b1;
      if (mgmt_wr) begin
        unique case (mgmt_addr)
          REG_BASIC_CONTROL:   next_s.basic_ctl = mgmt_wdata;
          REG_CTRL_STATUS_TWO: next_s.cs2 = mgmt_wdata & CS2_RW_MASK;
          REG_LED_CONTROL:     next_s.led_ctl = mgmt_wdata;
          REG_LOWPOWER_ADV:    next_s.lp_adv = mgmt_wdata;
          REG_GP_CLOCK_CTRL:   next_s.gpc = mgmt_wdata;
          default:             next_s.rdata = s.rdata;
        endcase
        next_s.rdata = '0;
      end else begin
        unique case (mgmt_addr)
          REG_BASIC_CONTROL:   next_s.rdata = s.basic_ctl;
          REG_CTRL_STATUS_TWO: begin
            next_s.rdata = s.cs2;
            next_s.rdata[CS2_MODE_LSB +: 3] = 3'(s.mode);
            next_s.rdata[CS2_EEE_LINK_BIT]  = eee_link;
          end
          REG_LED_CONTROL:     next_s.rdata = s.led_ctl;
          REG_LOWPOWER_ADV:    next_s.rdata = s.lp_adv;
          REG_GP_CLOCK_CTRL:   next_s.rdata = s.gpc;
          default:             next_s.rdata = '0;
        endcase
      end
    end

    // general clock output divider
    next_s.gpclk = 1'b0;
    next_s.div_cnt = '0;
    if (s.mode != MODE_HW_PD && gp_en) begin
      unique case (gp_sel)
        GP_SEL_FREE_125: next_s.gpclk = !s.gpclk;
        GP_SEL_25: begin
          next_s.div_cnt = (s.div_cnt == DIV25_LAST) ? 3'h0 : s.div_cnt + 3'h1;
          next_s.gpclk   = (s.div_cnt == DIV25_LAST) ? !s.gpclk : s.gpclk;
        end
        GP_SEL_RECOVER:  next_s.gpclk = s.rc2;
        default:         next_s.gpclk = 1'b0;
      endcase
    end

    // LED: link solid, activity blink, software override
    if (reached(s.blink_cnt, BLINK_CYCLES)) begin
      next_s.blink_cnt = '0;
      next_s.blink_ph  = !s.blink_ph;
    end else begin
      next_s.blink_cnt = sat_inc(s.blink_cnt);
    end
    if (s.led_ctl[LED_OVERRIDE_BIT]) begin
      led_lit = s.led_ctl[LED_FORCE_ON_BIT];
    end else begin
      led_lit = link_up && !(link_activity && s.blink_ph);
    end
    next_s.led_out = led_lit ^ s.led_active_low;

    // MAC-side outputs: idle in soft power-down, all zero in hardware power-down, forwarded otherwise
    if (s.mode == MODE_SOFT_PD || s.mode == MODE_HW_PD) begin
      next_s.rxd    = '0;
      next_s.rx_ctl = 1'b0;
      next_s.rxclk  = (s.mode == MODE_SOFT_PD);
    end else begin
      next_s.rxd    = core_rxd;
      next_s.rx_ctl = core_rx_ctl;
      next_s.rxclk  = core_rx_clk;
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // clock and analog enables per mode
  assign clock_multiplier_en = (s.mode == MODE_NORMAL || s.mode == MODE_WAKE) ||
                               (s.mode != MODE_HW_PD && gp_en &&
                                gp_sel == GP_SEL_FREE_125);
  assign core_clock_en       = (s.mode == MODE_NORMAL || s.mode == MODE_WAKE);
  assign analog_en           = (s.mode == MODE_NORMAL || s.mode == MODE_WAKE);
  assign line_receive_en     = (s.mode != MODE_HW_PD && s.mode != MODE_SOFT_PD);
  assign phy_ready           = (s.mode == MODE_NORMAL);

  // MAC-side pins released in hardware power-down
  assign mac_out_oe        = (s.mode != MODE_HW_PD);
  assign mac_rxd           = s.rxd;
  assign mac_rx_ctl        = s.rx_ctl;
  assign receive_clock_out = s.rxclk;

  assign general_clock_out  = s.gpclk;
  assign led_pin_out        = s.led_out;
  assign led_pin_oe         = (s.mode != MODE_HW_PD) && !release_edge;
  assign mgmt_rdata         = s.rdata;
  assign mgmt_ack           = s.ack;
  assign link_bringup_start = s.bringup;
  assign link_pulse         = s.pulse;
  assign lpi_refresh        = s.refresh;
  assign power_mode         = s.mode;

endmodule // phy_power_mode_control

/* hw/phy_pm_pkg.sv */
// Constants, types and register map of the PHY power-mode controller.
// Assumes a single 250 MHz clock and a synchronous active-low reset.

package phy_pm_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ             = 250_000_000;
  localparam int WAKE_TIME_US       = 20;
  localparam int SILENCE_TIME_S     = 3;
  localparam int LINK_PULSE_TIME_S  = 1;
  localparam int REFRESH_TIME_US    = 200;
  localparam int BLINK_HALF_MS      = 50;
  localparam int CLK25_HZ           = 25_000_000;
  localparam int WAKE_CYCLES_DEF    = WAKE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int SILENCE_CYCLES_DEF = SILENCE_TIME_S * CLK_HZ;
  localparam int PULSE_CYCLES_DEF   = LINK_PULSE_TIME_S * CLK_HZ;
  localparam int REFRESH_CYCLES_DEF = REFRESH_TIME_US * (CLK_HZ / 1_000_000);
  localparam int BLINK_CYCLES_DEF   = BLINK_HALF_MS * (CLK_HZ / 1_000);
  localparam logic [2:0] DIV25_LAST = 3'(CLK_HZ / (2 * CLK25_HZ) - 1);

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [15:0] REG_BASIC_CONTROL   = 16'h0000;
  localparam logic [15:0] REG_CTRL_STATUS_TWO = 16'h0015;
  localparam logic [15:0] REG_LED_CONTROL     = 16'h001d;
  localparam logic [15:0] REG_LOWPOWER_ADV    = 16'h8001;
  localparam logic [15:0] REG_GP_CLOCK_CTRL   = 16'hff1f;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int BC_SOFT_PD_BIT   = 11;
  localparam int CS2_EDPD_EN_BIT  = 3;
  localparam int CS2_MODE_LSB     = 8;
  localparam int CS2_EEE_LINK_BIT = 12;
  localparam int LED_OVERRIDE_BIT = 0;
  localparam int LED_FORCE_ON_BIT = 1;
  localparam int ADV_100_BIT      = 1;
  localparam int GPC_ENABLE_BIT   = 0;
  localparam int GPC_SEL_LSB      = 1;

  // ----------------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------------
  localparam logic [15:0] BASIC_CONTROL_RST = 16'h0000;
  localparam logic [15:0] CS2_RST           = 16'h0000;
  localparam logic [15:0] CS2_RW_MASK       = 16'h00ff;
  localparam logic [15:0] LED_CONTROL_RST   = 16'h0000;
  localparam logic [15:0] LOWPOWER_ADV_RST  = 16'h0000;
  localparam logic [15:0] GP_CLOCK_RST      = 16'h0000;

  // clock output selections
  localparam logic [1:0] GP_SEL_FREE_125 = 2'h0;
  localparam logic [1:0] GP_SEL_25       = 2'h1;
  localparam logic [1:0] GP_SEL_RECOVER  = 2'h2;

  typedef enum logic [2:0] {
    MODE_HW_PD,
    MODE_NORMAL,
    MODE_SOFT_PD,
    MODE_ENERGY_PD,
    MODE_LPI,
    MODE_WAKE
  } pm_mode_t;

endpackage

/* sim/phy_pm_checker.sv */
// Port assertions of the power-mode controller.
// Assumes one clock domain with reset nrst; bound to every controller instance.
module phy_pm_checker #(
  parameter int MAC_WIDTH    = 4,
  parameter int WAKE_CYCLES  = 30,
  parameter int PULSE_CYCLES = 20
) (
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire logic                 mgmt_ack,
  input wire logic                 mac_out_oe,
  input wire logic                 analog_en,
  input wire logic                 general_clock_out,
  input wire logic [MAC_WIDTH-1:0] mac_rxd,
  input wire logic                 mac_rx_ctl,
  input wire logic                 receive_clock_out,
  input wire logic                 link_bringup_start,
  input wire logic                 frame_active,
  input wire logic                 mac_lpi_req,
  input wire logic                 link_pulse,
  input wire phy_pm_pkg::pm_mode_t power_mode
);
  import phy_pm_pkg::*;
  localparam int WK = WAKE_CYCLES + 1;
  localparam int PL = PULSE_CYCLES + 2;
  // all checks sample on the rising edge, off during reset
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  hw_pd_quiet_a: assert property (power_mode == MODE_HW_PD |->
    !mac_out_oe && !analog_en) else $error("live outputs in hardware power-down");
  hw_no_ack_a: assert property ($past(power_mode) == MODE_HW_PD |->
    !mgmt_ack) else $error("register answered in hardware power-down");
  hw_clock_off_a: assert property (power_mode == MODE_HW_PD &&
    $past(power_mode) == MODE_HW_PD |-> !general_clock_out) else $error("clock out runs");
  soft_idle_a: assert property ((power_mode == MODE_SOFT_PD)[*2] |-> mac_out_oe &&
    mac_rxd == '0 && !mac_rx_ctl && receive_clock_out) else $error("mac pins not idle");
  bringup_a: assert property ($past(power_mode) == MODE_SOFT_PD &&
    power_mode == MODE_NORMAL |-> link_bringup_start) else $error("no link bring-up");
  no_cut_frame_a: assert property (power_mode == MODE_NORMAL && frame_active |=>
    power_mode != MODE_LPI) else $error("idle entered during a frame");
  lpi_exit_a: assert property (power_mode == MODE_LPI && !mac_lpi_req |=>
    power_mode inside {MODE_WAKE, MODE_SOFT_PD, MODE_HW_PD}) else $error("idle not left");
  wake_time_a: assert property (power_mode == MODE_WAKE |-> ##[0:WK]
    power_mode != MODE_WAKE) else $error("wake sequence too long");
  edpd_pulse_a: assert property (power_mode == MODE_ENERGY_PD |-> ##[0:PL]
    (link_pulse || power_mode != MODE_ENERGY_PD)) else $error("no periodic link pulse");
  soft_prio_a: assert property ($past(power_mode) == MODE_SOFT_PD |->
    power_mode inside {MODE_SOFT_PD, MODE_NORMAL, MODE_HW_PD}) else $error("bad exit");
endmodule // phy_pm_checker

bind phy_power_mode_control phy_pm_checker #(.MAC_WIDTH(MAC_WIDTH),
  .WAKE_CYCLES(WAKE_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) i_checker (.*);

/* sim/phy_pm_partner.sv */
// Model of the MAC and the remote link partner facing the controller.
// Assumes the bench steers its wishes; outputs move after falling edges.
module phy_pm_partner (
  input  wire logic clk,
  input  wire logic cable,
  input  wire logic peer_eee,
  input  wire logic want_idle,
  input  wire logic peer_wake,
  input  wire logic sending,
  output logic      line_energy,
  output logic      link_up,
  output logic      link_speed_100,
  output logic      partner_adv_100,
  output logic      partner_wake,
  output logic      link_activity,
  output logic      frame_active,
  output logic      mac_lpi_req,
  output logic      recovered_clock_in
);
  // quiet line and mac until a cable is plugged
  initial {line_energy, link_up, link_speed_100, partner_adv_100, partner_wake} = 5'h0;
  initial {link_activity, frame_active, mac_lpi_req, recovered_clock_in} = 4'h0;
  // line side follows the cable, mac side its traffic
  always @(negedge clk) begin
    line_energy        <= cable;
    link_up            <= cable;
    link_speed_100     <= cable;
    partner_adv_100    <= cable & peer_eee;
    partner_wake       <= peer_wake;
    link_activity      <= sending;
    frame_active       <= sending;
    mac_lpi_req        <= want_idle & partner_adv_100 & !sending;
    recovered_clock_in <= cable & !recovered_clock_in;
  end
endmodule // phy_pm_partner

/* sim/phy_power_mode_control_test.sv */
// Bench of the power-mode controller: registers, modes, clock output, led.
// Assumes the checker binds itself and the partner model stands for mac and peer.
module phy_power_mode_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import phy_pm_pkg::*;
  logic        clk = 1'h0, nrst = 1'h0, reset_pin_n = 1'h0, strap_soft_pd = 1'h1;
  logic        strap_edpd_en = 1'h0, strap_eee_en = 1'h0, led_pin_in = 1'h1, gprev = 1'h0;
  logic        mgmt_wr = 1'h0, mgmt_rd = 1'h0, core_rx_ctl = 1'h0, core_rx_clk = 1'h0;
  logic        cable = 1'h0, peer_eee = 1'h0, want_idle = 1'h0, peer_wake = 1'h0;
  logic        sending = 1'h0, led_pin_out, led_pin_oe, mgmt_ack, line_energy;
  logic        partner_wake, recovered_clock_in, link_up, link_speed_100, partner_adv_100;
  logic        link_activity, frame_active, mac_lpi_req, mac_rx_ctl, receive_clock_out;
  logic        mac_out_oe, general_clock_out, clock_multiplier_en, core_clock_en, phy_ready;
  logic        analog_en, line_receive_en, link_bringup_start, link_pulse, lpi_refresh;
  logic [3:0]  core_rxd = 4'h0, mac_rxd;
  logic [15:0] mgmt_addr = 16'h0, mgmt_wdata = 16'h0, mgmt_rdata, r, q[$];
  logic [15:0] gsel[4] = '{16'h1, 16'h3, 16'h5, 16'h0};
  logic [15:0] gexp[4] = '{16'ha, 16'h2, 16'ha, 16'h0};
  logic [15:0] gcmu[4] = '{16'h1, 16'h0, 16'h0, 16'h0};
  pm_mode_t    power_mode;
  int          n_mismatch = 0, comparisons = 0, n_gc, n_lp, n_rf, seed = 32'h0bf653ec;
  phy_power_mode_control #(.WAKE_CYCLES(30), .SILENCE_CYCLES(50), .PULSE_CYCLES(20),
    .REFRESH_CYCLES(10), .BLINK_CYCLES(8)) i_dut (.*);
  phy_pm_partner i_partner (.*);
  // 250 MHz clock
  always #2 clk = ~clk;
  // counts clock output edges and pulses
  always @(posedge clk) begin
    n_gc += int'(general_clock_out !== gprev);
    gprev = general_clock_out;
    n_lp += int'(link_pulse === 1'h1);
    n_rf += int'(lpi_refresh === 1'h1);
  end
  // each answer is compared with the oldest note
  always @(negedge clk) begin
    if (mgmt_ack === 1'h1) begin
      if (q.size() == 0) chk("unasked ack", 16'h0, 16'h1);
      else chk("rdata", q.pop_front(), mgmt_rdata);
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, d, e);
    int i;
    q.push_back(e);
    {mgmt_wr, mgmt_rd, mgmt_addr, mgmt_wdata} = {w, !w, a, d};
    @(negedge clk);
    {mgmt_wr, mgmt_rd} = 2'h0;
    for (i = 0; i < 8 && q.size() > 0; i++) @(negedge clk);
    if (q.size() > 0) chk("ack wait", 16'h1, 16'h0);
    q.delete();
  endtask
  task automatic wait_mode(input pm_mode_t m, input int n);
    int i;
    for (i = 0; i < n && power_mode !== m; i++) @(negedge clk);
    chk("mode", 16'(m), 16'(power_mode));
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1'h1;
    chk("oe", 16'h0, 16'(mac_out_oe));
    mgmt_rd = 1'h1;
    @(negedge clk);
    mgmt_rd = 1'h0;
    repeat (4) @(negedge clk);
    reset_pin_n = 1'h1;
    wait_mode(MODE_SOFT_PD, 10);
    @(negedge clk);
    chk("idle pins", 16'h1, 16'({mac_rxd, mac_rx_ctl, receive_clock_out}));
    cable = 1'h1;
    repeat (8) @(negedge clk);
    chk("deaf", 16'(MODE_SOFT_PD), 16'(power_mode));
    chk("line rx", 16'h0, 16'(line_receive_en));
    acc(1'h0, REG_BASIC_CONTROL, 16'h0, 16'h0800);
    acc(1'h0, REG_GP_CLOCK_CTRL, 16'h0, GP_CLOCK_RST);
    acc(1'h0, 16'h1234, 16'h0, 16'h0);
    r = 16'($random(seed));
    acc(1'h1, REG_CTRL_STATUS_TWO, r, 16'h0);
    acc(1'h0, REG_CTRL_STATUS_TWO, 16'h0, (r & CS2_RW_MASK) | 16'h0200);
    foreach (gsel[k]) begin
      acc(1'h1, REG_GP_CLOCK_CTRL, gsel[k], 16'h0);
      @(negedge clk);
      n_gc = 0;
      repeat (10) @(negedge clk);
      chk("clock edges", gexp[k], 16'(n_gc));
      chk("multiplier", gcmu[k], 16'(clock_multiplier_en));
    end
    cable = 1'h0;
    acc(1'h1, REG_BASIC_CONTROL, 16'h0, 16'h0);
    wait_mode(MODE_NORMAL, 4);
    acc(1'h1, REG_CTRL_STATUS_TWO, 16'h0008, 16'h0);
    wait_mode(MODE_ENERGY_PD, 80);
    n_lp = 0;
    repeat (41) @(negedge clk);
    chk("edpd pulses", 16'h2, 16'(n_lp));
    cable = 1'h1;
    wait_mode(MODE_NORMAL, 6);
    peer_eee = 1'h1;
    acc(1'h1, REG_LOWPOWER_ADV, 16'h0002, 16'h0);
    acc(1'h0, REG_CTRL_STATUS_TWO, 16'h0, 16'h1108);
    chk("led", 16'h2, 16'({led_pin_oe, led_pin_out}));
    {sending, want_idle} = 2'h3;
    repeat (6) @(negedge clk);
    sending = 1'h0;
    wait_mode(MODE_LPI, 6);
    n_rf = 0;
    repeat (21) @(negedge clk);
    chk("refresh", 16'h2, 16'(n_rf));
    peer_wake = 1'h1;
    wait_mode(MODE_WAKE, 6);
    {peer_wake, want_idle} = 2'h0;
    wait_mode(MODE_NORMAL, 34);
    chk("ready", 16'h1, 16'(phy_ready));
    reset_pin_n = 1'h0;
    wait_mode(MODE_HW_PD, 4);
    close_out();
  end
endmodule // phy_power_mode_control_test
